// ===== dv/sc_system_control_sva.sv
`timescale 1ns/1ps
module sc_system_control_sva (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic nmi_request_o,
    input wire logic irq_mode_select_hi_o,
    input wire logic irq_mode_select_lo_o,
    input wire logic irq_mode0_o,
    input wire logic irq_mode2_o,
    input wire logic irq_mode_prohibited_o,
    input wire logic nmi_edge_select_o,
    input wire logic onchip_ram_enable_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // ==========
    // decode and register fields
    mode0_decode_a: assert property (irq_mode0_o == (!irq_mode_select_hi_o && !irq_mode_select_lo_o))
        else $error("mode 0 decode wrong");
    mode2_decode_a: assert property (irq_mode2_o == (irq_mode_select_hi_o && !irq_mode_select_lo_o))
        else $error("mode 2 decode wrong");
    mode_prohib_a: assert property (irq_mode_prohibited_o == irq_mode_select_lo_o)
        else $error("prohibited mode flag wrong");
    ctrl_write_a: assert property (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
        && wb_adr_i[7:2] == 6'h00 |=> onchip_ram_enable_o == wb_dat_i[0]
        && nmi_edge_select_o == wb_dat_i[3] && irq_mode_select_lo_o == wb_dat_i[4]
        && irq_mode_select_hi_o == wb_dat_i[5])
        else $error("control write not applied");
    rsvd_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:2] == 6'h00
        |-> wb_dat_o[7:6] == 2'h0 && wb_dat_o[2:1] == 2'h0 && wb_dat_o[31:8] == 24'h0)
        else $error("reserved bits read nonzero");
    reset_vals_a: assert property ($past(rst_i) |-> onchip_ram_enable_o && !nmi_edge_select_o
        && !irq_mode_select_hi_o && !irq_mode_select_lo_o && !wb_ack_o)
        else $error("values after reset wrong");
    // ==========
    // bus and nmi timing
    ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    nmi_pulse_a: assert property (nmi_request_o |=> !nmi_request_o)
        else $error("nmi request longer than one cycle");
    wr_c: cover property (wb_ack_o && wb_we_i);
    rd_c: cover property (wb_ack_o && !wb_we_i);
    nmi_c: cover property (nmi_request_o && nmi_edge_select_o);
endmodule
bind sc_system_control sc_system_control_sva sc_system_control_sva_inst (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .nmi_request_o(nmi_request_o),
    .irq_mode_select_hi_o(irq_mode_select_hi_o), .irq_mode_select_lo_o(irq_mode_select_lo_o),
    .irq_mode0_o(irq_mode0_o), .irq_mode2_o(irq_mode2_o),
    .irq_mode_prohibited_o(irq_mode_prohibited_o), .nmi_edge_select_o(nmi_edge_select_o),
    .onchip_ram_enable_o(onchip_ram_enable_o));

// ===== dv/system_control_bits_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) chk(n, e, g);
module system_control_bits_bench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, nmi = 1'b1;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, dat_o;
    logic ack, req, hi, lo, m0, m2, bad, edg, ram;
    logic [7:0] q;
    int num_errors = 0, comparisons = 0, reqs = 0, cycles = 0, r0;
    sc_system_control sc_system_control_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .nmi_i(nmi), .nmi_request_o(req),
        .irq_mode_select_hi_o(hi), .irq_mode_select_lo_o(lo), .irq_mode0_o(m0),
        .irq_mode2_o(m2), .irq_mode_prohibited_o(bad), .nmi_edge_select_o(edg),
        .onchip_ram_enable_o(ram));
    initial
    begin
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        cycles++;
        if (req === 1'b1)
            reqs++;
        if (cycles == 5000)
        begin
            num_errors++;
            give_verdict();
        end
    end
    // ==========
    // tasks
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
            $display("ERROR %s expected %h seen %h", n, e, g);
        if (g !== e)
            num_errors++;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h1;
        dat <= {24'h0, d};
        do
        begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask
    task automatic set_nmi(input logic v, input int exp);
        r0 = reqs;
        @(posedge clk_i);
        nmi <= v;
        repeat (10) @(posedge clk_i);
        `CHK("nmi requests", exp[7:0], 8'(reqs - r0))
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ==========
    // tests
    initial
    begin
        do_reset();
        wb(1'b0, 8'h00, 8'h00);
        `CHK("ctrl reset", 8'h01, q)
        wb(1'b0, 8'h04, 8'h00);
        `CHK("status reset", 8'h05, q)
        wb(1'b0, 8'h08, 8'h00);
        `CHK("nmi count reset", 8'h00, q)
        // reserved bits set, mode field kept legal
        wb(1'b1, 8'h00, 8'hef);
        wb(1'b0, 8'h00, 8'h00);
        `CHK("ctrl reserved", 8'h29, q)
        `CHK("edge select set", 8'h01, {7'h0, edg})
        for (int m = 0; m < 4; m += 2)
        begin
            wb(1'b1, 8'h00, 8'(m << 4) | 8'h01);
            `CHK("mode decode", {5'h0, m == 0, m == 2, m[0]}, {5'h0, m0, m2, bad})
            `CHK("mode bits", 8'(m), {6'h0, hi, lo})
        end
        set_nmi(1'b0, 1);
        set_nmi(1'b1, 0);
        wb(1'b1, 8'h00, 8'h08);
        `CHK("edge select rise", 8'h01, {7'h0, edg})
        set_nmi(1'b0, 0);
        set_nmi(1'b1, 1);
        `CHK("ram off", 8'h00, {7'h0, ram})
        wb(1'b1, 8'h04, 8'hff);
        wb(1'b0, 8'h04, 8'h00);
        `CHK("status ram off", 8'h01, q)
        wb(1'b0, 8'h08, 8'h00);
        `CHK("nmi count", 8'h02, q)
        wb(1'b1, 8'h08, 8'h00);
        wb(1'b0, 8'h08, 8'h00);
        `CHK("nmi count clear", 8'h00, q)
        wb(1'b1, 8'h10, 8'hff);
        wb(1'b0, 8'h10, 8'h00);
        `CHK("unmapped", 8'h00, q)
        do_reset();
        `CHK("ram after reset", 8'h01, {7'h0, ram})
        wb(1'b0, 8'h00, 8'h00);
        `CHK("ctrl after reset", 8'h01, q)
        give_verdict();
    end
endmodule

// ===== hdl/sc_nmi_edge.sv
`timescale 1ns/1ps
`include "sc_params.svh"

module sc_nmi_edge (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic nmi_i,
    input wire logic edge_select_i,
    output logic level_o,
    output logic request_o
);

    logic sync1_q;
    logic sync1_d;
    logic sync2_q;
    logic sync2_d;
    logic prev_q;
    logic prev_d;
    logic [1:0] warm_q;
    logic [1:0] warm_d;
    logic req_q;
    logic req_d;
    logic rise;
    logic fall;

    // ========================================
    // synchroniser and edge detection
    always_comb
    begin
        sync1_d = nmi_i;
        sync2_d = sync1_q;
        prev_d = sync2_q;
        warm_d = warm_q;
        if (warm_q != `SC_NMI_WARMUP)
        begin
            warm_d = warm_q + 2'h1;
        end
        rise = sync2_q & ~prev_q;
        fall = ~sync2_q & prev_q;
        // no request until the pipeline holds real pin samples
        req_d = (warm_q == `SC_NMI_WARMUP) & (edge_select_i ? rise : fall); // R2
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
            warm_q <= 2'h0;
            req_q <= 1'b0;
        end
        else
        begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            prev_q <= prev_d;
            warm_q <= warm_d;
            req_q <= req_d;
        end
    end

    assign level_o = prev_q;
    assign request_o = req_q;

endmodule

// ===== hdl/sc_params.svh
`ifndef SC_PARAMS_SVH
`define SC_PARAMS_SVH

// register byte offsets on the bus
`define SC_OFF_CTRL 8'h00
`define SC_OFF_STATUS 8'h04
`define SC_OFF_NMI_COUNT 8'h08

// field positions in the control register
`define SC_BIT_RAM_EN 0
`define SC_BIT_NMI_EDGE 3
`define SC_BIT_MODE_LO 4
`define SC_BIT_MODE_HI 5

// field positions in the status register
`define SC_BIT_NMI_LEVEL 0
`define SC_BIT_MODE_BAD 1
`define SC_BIT_RAM_ON 2

// reset values
`define SC_RST_MODE 2'h0
`define SC_RST_NMI_EDGE 1'h0
`define SC_RST_RAM_EN 1'h1
`define SC_RST_NMI_COUNT 8'h00

// mask of the writable control bits; bits 7, 6, 2 and 1 hold zero
`define SC_CTRL_WMASK 8'h39

// cycles after reset before the edge detector trusts its sampled level
`define SC_NMI_WARMUP 2'h3

`endif

// ===== hdl/sc_pkg.sv
package sc_pkg;

    typedef enum logic [1:0] {
        SC_MODE_0 = 2'b00,
        SC_MODE_BAD_LO = 2'b01,
        SC_MODE_2 = 2'b10,
        SC_MODE_BAD_HI = 2'b11
    } sc_mode_code_t;

    typedef enum logic [0:0] {
        SC_BUS_IDLE = 1'b0,
        SC_BUS_ACK = 1'b1
    } sc_bus_state_t;

    // classic wishbone request as seen by the slave
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } sc_wb_req_t;

    // control fields delivered to the interrupt controller and ram
    typedef struct packed {
        logic [1:0] irq_mode;
        logic nmi_edge_select;
        logic onchip_ram_enable;
    } sc_ctrl_t;

endpackage

// ===== hdl/sc_system_control.sv
`timescale 1ns/1ps
`include "sc_params.svh"

// How it works
// [R1] The two-bit mode field decodes 00 as mode 0, 10 as mode 2, and 01 or 11 as prohibited.
// [R2] The edge-select bit picks falling-edge (0) or rising-edge (1) detection on the nmi input.
// [R3] Bits 2 and 1 of the control register always read zero and ignore writes.
// [R4] Bit 6 of the control register always reads zero and is left unchanged by writes.
// [R5] Bit 0 gates the on-chip ram, and writing it to zero disables that ram.
// [R6] Bit 0 returns to one whenever reset is released, so the ram is enabled after every reset.
// [R7] Software never writes a prohibited mode code, and mode and edge-select both reset to zero.
module sc_system_control (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic nmi_i,
    output logic nmi_request_o,
    output logic irq_mode_select_hi_o,
    output logic irq_mode_select_lo_o,
    output logic irq_mode0_o,
    output logic irq_mode2_o,
    output logic irq_mode_prohibited_o,
    output logic nmi_edge_select_o,
    output logic onchip_ram_enable_o
);

    // ========================================
    // helper functions
    function automatic logic addr_hit(input logic [7:0] adr, input logic [7:0] off);
        addr_hit = (adr[7:2] == off[7:2]);
    endfunction

    function automatic sc_pkg::sc_mode_code_t mode_decode(input logic [1:0] code);
        sc_pkg::sc_mode_code_t m;
        case (code)
            2'b00: m = sc_pkg::SC_MODE_0;
            2'b10: m = sc_pkg::SC_MODE_2;
            2'b01: m = sc_pkg::SC_MODE_BAD_LO;
            2'b11: m = sc_pkg::SC_MODE_BAD_HI;
            default: m = sc_pkg::SC_MODE_BAD_HI;
        endcase
        mode_decode = m;
    endfunction

    // ========================================
    // declarations
    sc_pkg::sc_wb_req_t req;
    sc_pkg::sc_ctrl_t ctrl_q;
    sc_pkg::sc_ctrl_t ctrl_d;
    sc_pkg::sc_bus_state_t bus_q;
    sc_pkg::sc_bus_state_t bus_d;
    sc_pkg::sc_mode_code_t mode_d;
    logic mode0_q;
    logic mode0_d;
    logic mode2_q;
    logic mode2_d;
    logic prohib_q;
    logic prohib_d;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic [7:0] nmi_count_q;
    logic [7:0] nmi_count_d;
    logic [7:0] ctrl_image;
    logic [7:0] status_image;
    logic take;
    logic wr_ctrl;
    logic wr_count;
    logic nmi_level;
    logic nmi_event;

    assign req.cyc = wb_cyc_i;
    assign req.stb = wb_stb_i;
    assign req.we = wb_we_i;
    assign req.adr = wb_adr_i;
    assign req.sel = wb_sel_i;
    assign req.dat = wb_dat_i;

    // ========================================
    // nmi edge detector
    sc_nmi_edge u_nmi_edge (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .nmi_i(nmi_i),
        .edge_select_i(ctrl_q.nmi_edge_select),
        .level_o(nmi_level),
        .request_o(nmi_event)
    );

    // ========================================
    // bus handshake
    always_comb
    begin
        bus_d = bus_q;
        take = 1'b0;
        case (bus_q)
            sc_pkg::SC_BUS_IDLE:
            begin
                if (req.cyc && req.stb)
                begin
                    take = 1'b1;
                    bus_d = sc_pkg::SC_BUS_ACK;
                end
            end
            sc_pkg::SC_BUS_ACK:
            begin
                bus_d = sc_pkg::SC_BUS_IDLE;
            end
            default:
            begin
                bus_d = sc_pkg::SC_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bus_q <= sc_pkg::SC_BUS_IDLE;
        end
        else
        begin
            bus_q <= bus_d;
        end
    end

    assign wb_ack_o = (bus_q == sc_pkg::SC_BUS_ACK);

    // ========================================
    // register images
    always_comb
    begin
        ctrl_image = 8'h00; // R3 R4
        ctrl_image[`SC_BIT_RAM_EN] = ctrl_q.onchip_ram_enable;
        ctrl_image[`SC_BIT_NMI_EDGE] = ctrl_q.nmi_edge_select;
        ctrl_image[`SC_BIT_MODE_LO] = ctrl_q.irq_mode[0];
        ctrl_image[`SC_BIT_MODE_HI] = ctrl_q.irq_mode[1];
        status_image = 8'h00;
        status_image[`SC_BIT_NMI_LEVEL] = nmi_level;
        status_image[`SC_BIT_MODE_BAD] = irq_mode_prohibited_o;
        status_image[`SC_BIT_RAM_ON] = ctrl_q.onchip_ram_enable;
    end

    // ========================================
    // control register
    assign wr_ctrl = take && req.we && req.sel[0] && addr_hit(req.adr, `SC_OFF_CTRL);

    always_comb
    begin
        ctrl_d = ctrl_q;
        if (wr_ctrl)
        begin
            // only mode, edge-select and ram enable take write data
            ctrl_d.onchip_ram_enable = req.dat[`SC_BIT_RAM_EN]; // R5
            ctrl_d.nmi_edge_select = req.dat[`SC_BIT_NMI_EDGE]; // R2
            ctrl_d.irq_mode = {req.dat[`SC_BIT_MODE_HI], req.dat[`SC_BIT_MODE_LO]}; // R1
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_q.irq_mode <= `SC_RST_MODE; // R7
            ctrl_q.nmi_edge_select <= `SC_RST_NMI_EDGE; // R7
            ctrl_q.onchip_ram_enable <= `SC_RST_RAM_EN; // R6
        end
        else
        begin
            ctrl_q <= ctrl_d;
        end
    end

    // ========================================
    // decoded mode flags, registered in step with the control bits
    always_comb
    begin
        mode_d = mode_decode(ctrl_d.irq_mode);
        mode0_d = 1'b0;
        mode2_d = 1'b0;
        prohib_d = 1'b0;
        case (mode_d)
            sc_pkg::SC_MODE_0:
            begin
                mode0_d = 1'b1; // R1
            end
            sc_pkg::SC_MODE_2:
            begin
                mode2_d = 1'b1; // R1
            end
            default:
            begin
                prohib_d = 1'b1; // R1
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode0_q <= (mode_decode(`SC_RST_MODE) == sc_pkg::SC_MODE_0); // R7
            mode2_q <= (mode_decode(`SC_RST_MODE) == sc_pkg::SC_MODE_2); // R7
            prohib_q <= 1'b0;
        end
        else
        begin
            mode0_q <= mode0_d;
            mode2_q <= mode2_d;
            prohib_q <= prohib_d;
        end
    end

    // ========================================
    // nmi event counter
    assign wr_count = take && req.we && req.sel[0] && addr_hit(req.adr, `SC_OFF_NMI_COUNT);

    always_comb
    begin
        nmi_count_d = nmi_count_q;
        if (wr_count)
        begin
            nmi_count_d = `SC_RST_NMI_COUNT;
        end
        // an event in the clearing cycle is still counted
        if (nmi_event)
        begin
            if (wr_count)
            begin
                nmi_count_d = 8'h01;
            end
            else if (nmi_count_q != 8'hff)
            begin
                nmi_count_d = nmi_count_q + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            nmi_count_q <= `SC_RST_NMI_COUNT;
        end
        else
        begin
            nmi_count_q <= nmi_count_d;
        end
    end

    // ========================================
    // read data
    always_comb
    begin
        rdat_d = 32'h00000000;
        if (take && !req.we)
        begin
            if (addr_hit(req.adr, `SC_OFF_CTRL))
            begin
                rdat_d = {24'h000000, ctrl_image};
            end
            else if (addr_hit(req.adr, `SC_OFF_STATUS))
            begin
                rdat_d = {24'h000000, status_image};
            end
            else if (addr_hit(req.adr, `SC_OFF_NMI_COUNT))
            begin
                rdat_d = {24'h000000, nmi_count_q};
            end
            else
            begin
                rdat_d = 32'h00000000;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdat_q <= 32'h00000000;
        end
        else
        begin
            rdat_q <= rdat_d;
        end
    end

    assign wb_dat_o = rdat_q;

    // ========================================
    // outputs
    assign irq_mode_select_hi_o = ctrl_q.irq_mode[1];
    assign irq_mode_select_lo_o = ctrl_q.irq_mode[0];
    assign irq_mode0_o = mode0_q; // R1
    assign irq_mode2_o = mode2_q; // R1
    assign irq_mode_prohibited_o = prohib_q; // R1
    assign nmi_edge_select_o = ctrl_q.nmi_edge_select;
    assign onchip_ram_enable_o = ctrl_q.onchip_ram_enable; // R5
    assign nmi_request_o = nmi_event;

endmodule
